// ### design/etsq_pkg.sv
// etsq_pkg: constants, register map and carrier types of the event timestamp status queue
// Functional notes
// RULE1 - reading status reports the oldest pending capture, then advances the queue
// RULE2 - with no capture pending the status word reads all zeros
// RULE3 - status bits 15 to 11 ignore writes and read as zero
// RULE4 - bits 10:8 give lost events for the reported input, saturating at seven
// RULE5 - bits 7:6 give the count of new 16-bit timestamp fields minus one
// RULE6 - the new-field count compares against the previous capture, single or multiple
// RULE7 - bit 5 gives edge direction of the reported input, one meaning rising
// RULE8 - bits 4:2 give the lowest captured input number
// RULE9 - when events were lost, report the lowest captured input that lost some
// RULE10 - bit 1 flags coincident inputs; extended status then leads the data reads
// RULE11 - bit 0 is set whenever the reported entry holds a captured event
// RULE12 - after reset all fields read zero and the queue is empty
// RULE13 - data order: extended status, ns low, ns high, seconds low, seconds high
// RULE14 - extended status holds a direction bit and a detect bit per input
package etsq_pkg;

  // structure of the capture path
  localparam int unsigned NUM_INPUTS  = 8;
  localparam int unsigned QUEUE_DEPTH = 4;
  localparam int unsigned QPTR_W      = 2;
  localparam int unsigned QCNT_W      = 3;
  localparam int unsigned IN_NUM_W    = 3;

  // time base: the counter advances by one clock period each cycle
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [29:0] NS_STEP       = 30'(CLK_PERIOD_NS);
  localparam logic [29:0] NS_PER_SEC    = 30'h3B9ACA00;

  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_EVENT_QUEUE_STATUS = 6'h1E;
  localparam logic [5:0] IDX_EVENT_CAPTURE_DATA = 6'h1F;
  localparam logic [5:0] IDX_EVENT_INPUT_CTRL   = 6'h20;

  // status word field positions
  localparam int unsigned ST_LOST_LSB = 8;
  localparam int unsigned ST_LEN_LSB  = 6;
  localparam int unsigned ST_EDGE_BIT = 5;
  localparam int unsigned ST_NUM_LSB  = 2;
  localparam int unsigned ST_MULT_BIT = 1;
  localparam int unsigned ST_DET_BIT  = 0;
  localparam logic [2:0]  LOST_SAT    = 3'h7;

  // new-field length codes
  localparam logic [1:0] LEN_NS_LO  = 2'h0;
  localparam logic [1:0] LEN_NS_HI  = 2'h1;
  localparam logic [1:0] LEN_SEC_LO = 2'h2;
  localparam logic [1:0] LEN_SEC_HI = 2'h3;

  // read phases of the capture data register
  localparam logic [2:0] PH_EXT    = 3'h0;
  localparam logic [2:0] PH_NS_LO  = 3'h1;
  localparam logic [2:0] PH_NS_HI  = 3'h2;
  localparam logic [2:0] PH_SEC_LO = 3'h3;
  localparam logic [2:0] PH_SEC_HI = 3'h4;
  localparam logic [2:0] PH_DONE   = 3'h5;

  // control register layout and reset value
  localparam int unsigned CTRL_RISE_BIT = 8;
  localparam int unsigned CTRL_FALL_BIT = 9;
  localparam logic [7:0]  CTRL_ENABLE_RESET = 8'hFF;
  localparam logic        CTRL_RISE_RESET   = 1'h1;
  localparam logic        CTRL_FALL_RESET   = 1'h1;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } etsq_wb_req_s;

  // one queue entry: status word, extended status and timestamp
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] ext;
    logic [29:0] ns;
    logic [31:0] sec;
  } etsq_entry_s;

  // software control of the event inputs
  typedef struct packed {
    logic       fallEn;
    logic       riseEn;
    logic [7:0] enable;
  } etsq_ctrl_s;

endpackage : etsq_pkg

// ### design/etsq_status_queue.sv
// etsq_status_queue: event capture queue with status and data registers on wishbone
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
module etsq_status_queue
  import etsq_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire etsq_wb_req_s          wbReq,
  output logic                       wbAck,
  output logic [31:0]                wbDatOut,
  input  wire logic [NUM_INPUTS-1:0] evtIn
);

  logic [NUM_INPUTS-1:0] evtSync;
  logic [NUM_INPUTS-1:0] evtPrev_q;
  logic [NUM_INPUTS-1:0] riseHit;
  logic [NUM_INPUTS-1:0] fallHit;
  logic [NUM_INPUTS-1:0] hit;
  logic [NUM_INPUTS-1:0] lostHit;
  logic [29:0]           ns_q;
  logic [31:0]           sec_q;
  logic [29:0]           lastNs_q;
  logic [31:0]           lastSec_q;
  logic [2:0]            missCnt_q [NUM_INPUTS];
  etsq_entry_s           mem_q [QUEUE_DEPTH];
  etsq_entry_s           newEntry;
  etsq_entry_s           cur_q;
  logic [2:0]            phase_q;
  logic [QPTR_W-1:0]     wrPtr_q;
  logic [QPTR_W-1:0]     rdPtr_q;
  logic [QCNT_W-1:0]     count_q;
  logic                  full;
  logic                  empty;
  logic                  push;
  logic                  pop;
  logic [2:0]            repNum;
  logic [1:0]            newLen;
  logic                  multi;
  etsq_ctrl_s            ctrl_q;
  logic                  access;
  logic [5:0]            regIdx;
  logic                  readStatus;
  logic                  readData;
  logic                  writeCtrl;
  logic [15:0]           dataWord;
  logic [31:0]           readMux;

  // event pins come from outside the clock domain
  // two flops add two cycles of capture latency but keep metastability out of the queue
  etsq_sync #(
    .WIDTH (NUM_INPUTS)
  ) u_evt_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (evtIn),
    .syncOut (evtSync)
  );

  // previous synchronised level for edge detection
  // reset level matches the idle pin level, so no false edge follows reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evtPrev_q <= '0;
    end else begin
      evtPrev_q <= evtSync;
    end
  end

  // qualified edges; disabled inputs and directions never reach the queue
  assign riseHit = evtSync & ~evtPrev_q & ctrl_q.enable & {NUM_INPUTS{ctrl_q.riseEn}};
  assign fallHit = ~evtSync & evtPrev_q & ctrl_q.enable & {NUM_INPUTS{ctrl_q.fallEn}};
  assign hit     = riseHit | fallHit;

  // free-running time base in nanoseconds and seconds
  // the wrap takes off a whole second so the nanosecond field never reaches one second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ns_q  <= '0;
      sec_q <= '0;
    end else if (ns_q >= NS_PER_SEC - NS_STEP) begin
      ns_q  <= ns_q + NS_STEP - NS_PER_SEC;
      sec_q <= sec_q + 32'h00000001;
    end else begin
      ns_q <= ns_q + NS_STEP;
    end
  end

  // queue occupancy; a full queue drops new captures
  // dropping keeps queued timestamps intact; the loss is counted per input instead
  assign empty = (count_q == '0);
  assign full  = (count_q == QCNT_W'(QUEUE_DEPTH));
  assign push  = (|hit) && !full;

  // captured inputs that have lost events before this capture
  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      lostHit[i] = hit[i] && (missCnt_q[i] != 3'h0);
    end
  end

  // pick the reported input; loop runs downward so the lowest index wins
  always_comb begin
    repNum = '0;
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      // RULE9 lowest lossy input
      if (|lostHit) begin
        if (lostHit[i]) begin
          repNum = IN_NUM_W'(i);
        end
      // RULE8 lowest captured input
      end else if (hit[i]) begin
        repNum = IN_NUM_W'(i);
      end
    end
  end

  // more than one input at the same instant
  // clearing the lowest set bit leaves a nonzero word only for two or more hits
  assign multi = ((hit & (hit - NUM_INPUTS'(1))) != '0);

  // RULE6 compare with previous capture
  always_comb begin
    if (sec_q[31:16] != lastSec_q[31:16]) begin
      newLen = LEN_SEC_HI;
    end else if (sec_q[15:0] != lastSec_q[15:0]) begin
      newLen = LEN_SEC_LO;
    end else if (ns_q[29:16] != lastNs_q[29:16]) begin
      newLen = LEN_NS_HI;
    end else begin
      newLen = LEN_NS_LO;
    end
  end

  // assemble the entry written on a push
  always_comb begin
    newEntry        = '0;
    // RULE4 lost count of reported input
    newEntry.status[ST_LOST_LSB +: 3] = missCnt_q[repNum];
    // RULE5 new-field length code
    newEntry.status[ST_LEN_LSB +: 2]  = newLen;
    // RULE7 direction of reported input
    newEntry.status[ST_EDGE_BIT]      = riseHit[repNum];
    newEntry.status[ST_NUM_LSB +: 3]  = repNum;
    // RULE10 coincident capture flag
    newEntry.status[ST_MULT_BIT]      = multi;
    // RULE11 capture present flag
    newEntry.status[ST_DET_BIT]       = 1'b1;
    // RULE14 direction and detect pairs
    for (int i = 0; i < NUM_INPUTS; i++) begin
      newEntry.ext[2*i]   = hit[i];
      newEntry.ext[2*i+1] = riseHit[i];
    end
    newEntry.ns  = ns_q;
    newEntry.sec = sec_q;
  end

  // previous capture time, the reference for the length code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lastNs_q  <= '0;
      lastSec_q <= '0;
    end else if (push) begin
      lastNs_q  <= ns_q;
      lastSec_q <= sec_q;
    end
  end

  // RULE4 saturating lost-event counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        missCnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (hit[i] && full) begin
          if (missCnt_q[i] != LOST_SAT) begin
            missCnt_q[i] <= missCnt_q[i] + 3'h1;
          end
        end else if (push && (repNum == IN_NUM_W'(i))) begin
          // only the reported input's count is consumed; others wait for their turn
          missCnt_q[i] <= '0;
        end
      end
    end
  end

  // wishbone decode; one access per request, ack gates the repeat
  assign access     = wbReq.cyc && wbReq.stb && !wbAck;
  assign regIdx     = wbReq.adr[7:2];
  assign readStatus = access && !wbReq.we && (regIdx == IDX_EVENT_QUEUE_STATUS);
  assign readData   = access && !wbReq.we && (regIdx == IDX_EVENT_CAPTURE_DATA);
  assign writeCtrl  = access && wbReq.we && (regIdx == IDX_EVENT_INPUT_CTRL);
  // RULE1 status read pops the head
  assign pop        = readStatus && !empty;

  // RULE12 queue storage and pointers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        mem_q[wrPtr_q] <= newEntry;
        wrPtr_q        <= wrPtr_q + QPTR_W'(1);
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + QPTR_W'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + QCNT_W'(1);
      end else if (pop && !push) begin
        count_q <= count_q - QCNT_W'(1);
      end
    end
  end

  // a data read past the last word stays in the done phase until the next status read
  // RULE13 entry held for data reads, walked in fixed order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_q   <= '0;
      phase_q <= PH_DONE;
    end else if (readStatus) begin
      if (empty) begin
        // RULE2 no capture leaves data invalid
        cur_q   <= '0;
        phase_q <= PH_DONE;
      end else begin
        cur_q   <= mem_q[rdPtr_q];
        // RULE10 extended status read first
        phase_q <= mem_q[rdPtr_q].status[ST_MULT_BIT] ? PH_EXT : PH_NS_LO;
      end
    end else if (readData && (phase_q != PH_DONE)) begin
      phase_q <= phase_q + 3'h1;
    end
  end

  // current word of the capture data register; past the last word it reads zero
  always_comb begin
    unique case (phase_q)
      PH_EXT:    dataWord = cur_q.ext;
      PH_NS_LO:  dataWord = cur_q.ns[15:0];
      PH_NS_HI:  dataWord = {2'h0, cur_q.ns[29:16]};
      PH_SEC_LO: dataWord = cur_q.sec[15:0];
      PH_SEC_HI: dataWord = cur_q.sec[31:16];
      default:   dataWord = 16'h0000;
    endcase
  end

  // read multiplexer; unmapped addresses read zero
  // the status view is combinational so a read sees the head at the edge that pops it
  always_comb begin
    readMux = 32'h00000000;
    if (regIdx == IDX_EVENT_QUEUE_STATUS) begin
      // RULE3 reserved bits read zero
      readMux = {16'h0000, 5'h00, (empty ? 11'h000 : mem_q[rdPtr_q].status[10:0])};
    end else if (regIdx == IDX_EVENT_CAPTURE_DATA) begin
      readMux = {16'h0000, dataWord};
    end else if (regIdx == IDX_EVENT_INPUT_CTRL) begin
      readMux = {22'h000000, ctrl_q.fallEn, ctrl_q.riseEn, ctrl_q.enable};
    end
  end

  // input control register, byte lanes honoured
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q.enable <= CTRL_ENABLE_RESET;
      ctrl_q.riseEn <= CTRL_RISE_RESET;
      ctrl_q.fallEn <= CTRL_FALL_RESET;
    end else if (writeCtrl) begin
      if (wbReq.sel[0]) begin
        ctrl_q.enable <= wbReq.dat[7:0];
      end
      if (wbReq.sel[1]) begin
        ctrl_q.riseEn <= wbReq.dat[CTRL_RISE_BIT];
        ctrl_q.fallEn <= wbReq.dat[CTRL_FALL_BIT];
      end
    end
  end

  // ack one cycle after the request, every address answers
  // data is zero outside ack so no stale word lingers on the read path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wbAck    <= 1'b0;
      wbDatOut <= '0;
    end else begin
      wbAck <= access;
      if (access && !wbReq.we) begin
        wbDatOut <= readMux;
      end else begin
        wbDatOut <= '0;
      end
    end
  end

endmodule : etsq_status_queue

// ### design/etsq_sync.sv
// etsq_sync: two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/100ps
module etsq_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : etsq_sync

// ### tb/etsq_status_queue_props.sv
// etsq_status_queue_props: port checker of the event timestamp status queue
`timescale 1ns/100ps
module etsq_status_queue_props
  import etsq_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire etsq_wb_req_s          wbReq,
  input wire logic                  wbAck,
  input wire logic [31:0]           wbDatOut,
  input wire logic [NUM_INPUTS-1:0] evtIn
);
  logic stRd;
  // request is still held in the ack cycle, so its address qualifies the answer
  assign stRd = wbAck && !wbReq.we && (wbReq.adr == 8'h78);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ack_after_req_a:
    assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck) else $error("no ack");
  ack_one_pulse_a:
    assert property (wbAck |=> !wbAck) else $error("ack held");
  reserved_zero_a:
    assert property (stRd |-> wbDatOut[31:11] == 21'h0) else $error("reserved set");
  empty_reads_zero_a:
    assert property (stRd && !wbDatOut[0] |-> wbDatOut == 32'h0) else $error("empty nonzero");
  mult_needs_event_a:
    assert property (stRd && wbDatOut[1] |-> wbDatOut[0]) else $error("mult alone");
  lost_needs_event_a:
    assert property (stRd && wbDatOut[10:8] != 3'h0 |-> wbDatOut[0]) else $error("lost alone");
  idle_data_zero_a:
    assert property (!wbAck |-> wbDatOut == 32'h0) else $error("data outside ack");
  data_upper_zero_a:
    assert property (wbAck && wbReq.adr == 8'h7C |-> wbDatOut[31:16] == 16'h0)
      else $error("data upper set");
endmodule : etsq_status_queue_props

bind etsq_status_queue etsq_status_queue_props u_props (
  .clk(clk), .rst_b(rst_b), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .evtIn(evtIn)
);

// ### tb/etsq_status_queue_tb.sv
// etsq_status_queue_tb: randomised bench of the event timestamp status queue
`timescale 1ns/100ps
module etsq_status_queue_tb
  import etsq_pkg::*;
;
  logic                  clk;
  logic                  rst_b;
  etsq_wb_req_s          wbReq;
  logic                  wbAck;
  logic [31:0]           wbDatOut;
  logic [NUM_INPUTS-1:0] evtIn;
  int                    num_errors;
  int                    num_checks;
  logic [31:0]           lfsr;
  logic [31:0]           rd;
  logic [2:0]            a;
  logic [2:0]            b;
  logic [7:0]            m;

  etsq_status_queue DUT (.clk(clk), .rst_b(rst_b), .wbReq(wbReq), .wbAck(wbAck),
                         .wbDatOut(wbDatOut), .evtIn(evtIn));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // expected status word of a present capture
  function automatic logic [31:0] stat(input logic [2:0] lost, input logic [1:0] len,
                                       input logic rise, input logic [2:0] num, input logic mult);
    return {21'h0, lost, len, rise, num, mult, 1'b1};
  endfunction : stat

  // expected extended word: detect bit even, direction bit odd
  function automatic logic [31:0] extw(input logic [7:0] msk, input logic rise);
    logic [31:0] e;
    e = '0;
    for (int i = 0; i < 8; i++) begin
      e[2*i]   = msk[i];
      e[2*i+1] = msk[i] & rise;
    end
    return e;
  endfunction : extw

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one classic cycle; ack and data are sampled at the rising edge, released right after it
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk);
    wbReq <= '{1'b1, 1'b1, we, adr, sel, dat};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) num_errors++;
    rd = wbDatOut;
    wbReq <= '0;
  endtask : wb

  task automatic rdck(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, 4'h0);
    check(rd, exp);
  endtask : rdck

  // pins change at the edge; capture lands three edges later
  task automatic toggle(input logic [7:0] msk);
    @(posedge clk);
    evtIn <= evtIn ^ msk;
    repeat (5) @(posedge clk);
  endtask : toggle

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // watchdog: the run needs under ten thousand cycles
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end

  initial begin
    wbReq = '0;
    evtIn = '0;
    rst_b = 1'b0;
    num_errors = 0;
    num_checks = 0;
    lfsr = 32'h945860F5;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rdck(8'h78, 32'h0);
    rdck(8'h7C, 32'h0);
    rdck(8'h80, 32'h3FF);
    rdck(8'h40, 32'h0);
    $display("test reset done");
    lfsr = lfsr_next(lfsr);
    a = lfsr[2:0];
    toggle(8'h1 << a);
    rdck(8'h78, stat(3'h0, 2'h0, 1'h1, a, 1'h0));
    wb(1'b0, 8'h7C, 32'h0, 4'h0);
    check(rd % 10, 32'h0);
    for (int k = 0; k < 4; k++) rdck(8'h7C, 32'h0);
    rdck(8'h78, 32'h0);
    toggle(8'h1 << a);
    rdck(8'h78, stat(3'h0, 2'h0, 1'h0, a, 1'h0));
    $display("test single done");
    lfsr = lfsr_next(lfsr);
    b = a ^ (lfsr[2:0] | 3'h1);
    m = (8'h1 << a) | (8'h1 << b);
    toggle(m);
    rdck(8'h78, stat(3'h0, 2'h0, 1'h1, (a < b) ? a : b, 1'h1));
    rdck(8'h7C, extw(m, 1'b1));
    wb(1'b0, 8'h7C, 32'h0, 4'h0);
    check(rd % 10, 32'h0);
    toggle(m);
    rdck(8'h78, stat(3'h0, 2'h0, 1'h0, (a < b) ? a : b, 1'h1));
    rdck(8'h7C, extw(m, 1'b0));
    $display("test multiple done");
    wb(1'b1, 8'h78, 32'hFFFF, 4'hF);
    rdck(8'h78, 32'h0);
    wb(1'b1, 8'h80, 32'hF7, 4'h1);
    rdck(8'h80, 32'h3F7);
    toggle(8'h08);
    rdck(8'h78, 32'h0);
    wb(1'b1, 8'h80, 32'hFF, 4'h1);
    toggle(8'h08);
    rdck(8'h78, stat(3'h0, 2'h0, 1'h0, 3'h3, 1'h0));
    $display("test control done");
    // fill the queue, then drop nine edges of input two
    repeat (4) toggle(8'h01);
    repeat (9) toggle(8'h04);
    for (int k = 0; k < 4; k++) rdck(8'h78, stat(3'h0, 2'h0, ~k[0], 3'h0, 1'h0));
    toggle(8'h06);
    rdck(8'h78, stat(3'h7, 2'h0, 1'h0, 3'h2, 1'h1));
    toggle(8'h04);
    rdck(8'h78, stat(3'h0, 2'h0, 1'h1, 3'h2, 1'h0));
    $display("test lost done");
    // long gap moves the upper nanoseconds word
    repeat (7000) @(posedge clk);
    toggle(8'h30);
    rdck(8'h78, stat(3'h0, 2'h1, 1'h1, 3'h4, 1'h1));
    toggle(8'h10);
    rdck(8'h78, stat(3'h0, 2'h0, 1'h0, 3'h4, 1'h0));
    $display("test length done");
    finish_test();
  end
endmodule : etsq_status_queue_tb
